// ### sirf_top.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "sirf_cfg.svh"
// What this block does
// - Low-supply comparator below threshold holds reset pin low, chip in reset.
// - Low-supply detector exists only by option; option picks low, medium, high threshold.
// - Watchdog underflow drives reset pin low for at least the minimum pulse.
// - Illegal opcode or prebyte detected at decode also starts a reset.
// - Supply warning flag and interrupt work only with low-supply detector enabled.
// - Warning flag in bit 5 follows comparator live; read-only; 1 means low.
// - With bit 6 enable set, every warning flag change requests an interrupt.
// - Warning interrupt delivered only when enabled and CPU mask is clear.
// - Pending warning request clears itself when CPU enters its service routine.
// - Rising crossing within the reset delay raises no warning interrupt.
// - Enabling while supply still low gives one request now, one at crossing.
// - Enabling after the supply already passed the threshold gives exactly one request.
// - Wait mode changes nothing; a warning interrupt wakes the device from wait.
// - Halt freezes the register; warning interrupt does not wake from halt.
// - Bit 4 set on low-supply reset; software clears by writing zero.
// - Bit 0 set on watchdog reset, cleared by low-supply reset or zero write.
// - Low-supply flag survives later pin or watchdog resets until software clears it.
// - Flags read 00 after pin reset, 01 after watchdog, 1x after low supply.
// - Bit 7 reads zero; software keeps bits 3:1 cleared on writes.
// - After release wait 4096 or 256 cycles, then two vector fetch cycles.
// - Warning request serviced only above current level, else stays pending.
module sirf_top
   import sirf_pkg::*;
#(
   parameter int WDG_PULSE_NS = 1000,
   parameter int DLY_W        = 13,
   parameter int PW_W         = 16
) (
   // Clock and power-on reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Analog comparators, asynchronous
   input  wire logic        lvd_below_async,
   input  wire logic        avd_below_async,
   output logic             lvd_enable,
   output logic [1:0]       lvd_level,
   // Option straps, caught once after power-on reset
   input  wire logic        opt_lvd_en,
   input  wire logic [1:0]  opt_lvd_level,
   input  wire logic        opt_short_delay,
   // Reset sources
   input  wire logic        wdg_underflow,
   input  wire logic        illegal_opcode,
   // Open-drain reset pin
   input  wire logic        rst_pin_in,
   output logic             rst_pin_out,
   output logic             rst_pin_oe,
   // Core reset sequencing
   output logic             chip_reset,
   output logic             vector_fetch,
   // CPU and interrupt controller
   input  wire logic        cpu_irq_masked,
   input  wire logic [1:0]  cpu_level,
   input  wire logic        irq_ack,
   input  wire logic        cpu_wait,
   input  wire logic        cpu_halt,
   output logic             warn_irq,
   output logic             wake_wait
);

   localparam int PULSE_RAW =
      (WDG_PULSE_NS + `SIRF_CLK_PERIOD_NS - 1) / `SIRF_CLK_PERIOD_NS;
   localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

   localparam logic [DLY_W-1:0] DLY_LONG_M1  = DLY_W'(`SIRF_DELAY_LONG - 1);
   localparam logic [DLY_W-1:0] DLY_SHORT_M1 = DLY_W'(`SIRF_DELAY_SHORT - 1);
   localparam logic [DLY_W-1:0] FETCH_M1     = DLY_W'(`SIRF_FETCH_CYC - 1);
   localparam logic [PW_W-1:0]  PULSE_LOAD   = PW_W'(PULSE_CYC);

   if ((2 ** DLY_W) < `SIRF_DELAY_LONG) begin : g_chk_dly
      $error("DLY_W too small for the reset delay");
   end
   if ((2 ** PW_W) <= PULSE_CYC) begin : g_chk_pw
      $error("PW_W too small for the watchdog pulse");
   end

   // Comparator synchronisers: bit 0 low-supply, bit 1 warning
   logic [1:0] cmp_async;
   logic [1:0] cmp_sync;

   assign cmp_async = {avd_below_async, lvd_below_async};

   for (genvar i = 0; i < 2; i++) begin : g_sync
      logic [`SIRF_SYNC_STAGES-1:0] stage;
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            stage <= '0;
         end else begin
            stage <= {stage[`SIRF_SYNC_STAGES-2:0], cmp_async[i]};
         end
      end
      assign cmp_sync[i] = stage[`SIRF_SYNC_STAGES-1];
   end

   // Option capture; the straps may not be stable during power-on reset
   sirf_opt_t opt;
   logic      opt_loaded;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         opt        <= '0;
         opt_loaded <= 1'b0;
      end else if (!opt_loaded) begin
         opt        <= '{opt_short_delay, opt_lvd_level, opt_lvd_en};
         opt_loaded <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lvd_enable <= 1'b0;
         lvd_level  <= 2'h0;
      end else begin
         lvd_enable <= opt.lvd_en;
         lvd_level  <= opt.level;
      end
   end

   // Reset sources
   logic            lvd_req;
   logic            ext_req;
   logic            pulse_start;
   logic            pulse_busy;
   logic            any_req;
   logic [PW_W-1:0] pulse_cnt;
   logic [PW_W-1:0] next_pulse_cnt;

   assign lvd_req     = opt.lvd_en & cmp_sync[0];
   assign pulse_start = wdg_underflow | illegal_opcode;
   assign pulse_busy  = (pulse_cnt != '0);
   // Own drive shows on the pin too, so only a low we do not drive is external
   assign ext_req     = ~rst_pin_in & ~rst_pin_oe;
   assign any_req     = lvd_req | pulse_start | pulse_busy | ext_req;

   assign next_pulse_cnt = pulse_start ? PULSE_LOAD :
                           pulse_busy  ? pulse_cnt - PW_W'(1) :
                                         pulse_cnt;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_cnt <= '0;
      end else begin
         pulse_cnt <= next_pulse_cnt;
      end
   end

   // Reset sequence
   sirf_seq_t        seq;
   sirf_seq_t        next_seq;
   logic [DLY_W-1:0] dly_cnt;
   logic [DLY_W-1:0] next_dly_cnt;
   logic [DLY_W-1:0] dly_last;

   assign dly_last = opt.short_delay ? DLY_SHORT_M1 : DLY_LONG_M1;

   always_comb begin
      next_seq     = seq;
      next_dly_cnt = dly_cnt + DLY_W'(1);
      unique case (seq)
         SIRF_RUN: begin
            if (any_req) begin
               next_seq = SIRF_ACTIVE;
            end
         end
         SIRF_ACTIVE: begin
            next_dly_cnt = '0;
            if (!any_req) begin
               next_seq = SIRF_DELAY;
            end
         end
         SIRF_DELAY: begin
            if (any_req) begin
               next_seq = SIRF_ACTIVE;
            end else if (dly_cnt == dly_last) begin
               next_seq     = SIRF_FETCH;
               next_dly_cnt = '0;
            end
         end
         SIRF_FETCH: begin
            if (any_req) begin
               next_seq = SIRF_ACTIVE;
            end else if (dly_cnt == FETCH_M1) begin
               next_seq = SIRF_RUN;
            end
         end
      endcase
   end

   // Power-on reset runs through the delay phase as well
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         seq     <= SIRF_DELAY;
         dly_cnt <= '0;
      end else begin
         seq     <= next_seq;
         dly_cnt <= next_dly_cnt;
      end
   end

   logic next_pin_oe;
   logic next_chip_reset;

   // Pin held low through the active and delay phases
   assign next_pin_oe     = (next_seq == SIRF_ACTIVE) | (next_seq == SIRF_DELAY);
   assign next_chip_reset = next_pin_oe;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_pin_out  <= 1'b0;
         rst_pin_oe   <= 1'b1;
         chip_reset   <= 1'b1;
         vector_fetch <= 1'b0;
      end else begin
         rst_pin_out  <= 1'b0;
         rst_pin_oe   <= next_pin_oe;
         chip_reset   <= next_chip_reset;
         vector_fetch <= (next_seq == SIRF_FETCH);
      end
   end

   // Bus address phase
   sirf_ap_t ap;
   logic     take;
   logic     csr_hit;
   logic     prio_hit;
   logic     csr_wr;
   logic     prio_wr;
   logic     seq_busy;

   assign take     = hsel & hready & (htrans == `SIRF_HTRANS_NONSEQ);
   assign csr_hit  = (ap.idx == `SIRF_CSR_IDX);
   assign prio_hit = (ap.idx == `SIRF_PRIO_IDX);
   // Halt freezes the register, so writes are dropped then
   assign csr_wr   = ap.valid & ap.write & csr_hit & ~cpu_halt;
   assign prio_wr  = ap.valid & ap.write & prio_hit & ~cpu_halt;
   assign seq_busy = (seq != SIRF_RUN);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ap <= '0;
      end else begin
         ap <= '{take, hwrite, haddr[9:2]};
      end
   end

   // Control/status register
   sirf_csr_t csr;
   sirf_csr_t next_csr;
   logic      wdg_event;
   logic      sw_clr_lvd;
   logic      sw_clr_wdg;

   assign wdg_event  = wdg_underflow & (seq == SIRF_RUN);
   assign sw_clr_lvd = csr_wr & ~hwdata[`SIRF_BIT_LVD];
   assign sw_clr_wdg = csr_wr & ~hwdata[`SIRF_BIT_WDG];

   // Hardware set wins over a software clear in the same cycle
   assign next_csr.lvd_flag = lvd_req | (csr.lvd_flag & ~sw_clr_lvd);
   assign next_csr.wdg_flag = ~lvd_req &
                              (wdg_event | (csr.wdg_flag & ~sw_clr_wdg));
   assign next_csr.warn_ie  = seq_busy ? 1'b0 :
                              csr_wr   ? hwdata[`SIRF_BIT_IE] :
                                         csr.warn_ie;

   // Reset-cause flags clear on power-on reset or a zero write; bit 0 also on low-supply reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         csr <= '0;
      end else begin
         csr <= next_csr;
      end
   end

   logic [`SIRF_PRIO_W-1:0] prio;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prio <= `SIRF_PRIO_RST;
      end else if (prio_wr) begin
         prio <= hwdata[`SIRF_PRIO_W-1:0];
      end
   end

   // Supply warning
   logic warn_flag;
   logic warn_live;
   logic warn_toggle;
   logic warn_pend;
   logic next_warn_pend;
   logic warn_req;

   assign warn_live   = opt.lvd_en & cmp_sync[1];
   assign warn_toggle = (warn_live != warn_flag) & ~cpu_halt;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         warn_flag <= 1'b0;
      end else if (!cpu_halt) begin
         warn_flag <= warn_live;
      end
   end

   // Latch catches every toggle outside the reset sequence; enable only gates delivery, so a toggle
   // seen before enabling is delivered once at enabling
   assign next_warn_pend = seq_busy    ? 1'b0 :
                           warn_toggle ? 1'b1 :
                           irq_ack     ? 1'b0 :
                                         warn_pend;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         warn_pend <= 1'b0;
      end else begin
         warn_pend <= next_warn_pend;
      end
   end

   assign warn_req = next_warn_pend & csr.warn_ie & opt.lvd_en;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         warn_irq  <= 1'b0;
         wake_wait <= 1'b0;
      end else begin
         warn_irq  <= warn_req & ~cpu_irq_masked & (prio > cpu_level);
         wake_wait <= warn_req & cpu_wait & ~cpu_halt;
      end
   end

   // Read data; one wait state so a write just before is seen
   logic [7:0]  csr_rd;
   logic [7:0]  opt_rd;
   logic [31:0] rd_mux;
   logic        rd_wait;

   always_comb begin
      csr_rd                 = 8'h00;
      csr_rd[`SIRF_BIT_IE]   = csr.warn_ie;
      csr_rd[`SIRF_BIT_FLAG] = warn_flag;
      csr_rd[`SIRF_BIT_LVD]  = csr.lvd_flag;
      csr_rd[`SIRF_BIT_WDG]  = csr.wdg_flag;
   end

   always_comb begin
      opt_rd                                          = 8'h00;
      opt_rd[`SIRF_OPT_BIT_EN]                        = opt.lvd_en;
      opt_rd[`SIRF_OPT_BIT_LVL+1:`SIRF_OPT_BIT_LVL]   = opt.level;
      opt_rd[`SIRF_OPT_BIT_SHORT]                     = opt.short_delay;
   end

   assign rd_mux = (ap.idx == `SIRF_CSR_IDX)  ? {24'h000000, csr_rd} :
                   (ap.idx == `SIRF_PRIO_IDX) ? {30'h00000000, prio} :
                   (ap.idx == `SIRF_OPT_IDX)  ? {24'h000000, opt_rd} :
                                                32'h00000000;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_wait   <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
      end else begin
         rd_wait   <= take & ~hwrite;
         hreadyout <= ~(take & ~hwrite);
         if (rd_wait) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hresp <= `SIRF_HRESP_OKAY;
      end else begin
         hresp <= `SIRF_HRESP_OKAY;
      end
   end

endmodule

// ### sirf_cfg.svh
`ifndef SIRF_CFG_SVH
`define SIRF_CFG_SVH

// Register indices; byte address is four times the index
`define SIRF_CSR_IDX        8'h25
`define SIRF_PRIO_IDX       8'h26
`define SIRF_OPT_IDX        8'h27

// Control/status field positions
`define SIRF_BIT_WDG        0
`define SIRF_BIT_LVD        4
`define SIRF_BIT_FLAG       5
`define SIRF_BIT_IE         6
`define SIRF_CSR_RST        8'h00
`define SIRF_PRIO_RST       2'h1
`define SIRF_PRIO_W         2

// Option readout field positions
`define SIRF_OPT_BIT_EN     0
`define SIRF_OPT_BIT_LVL    1
`define SIRF_OPT_BIT_SHORT  3

// Timing
`define SIRF_CLK_PERIOD_NS  10
`define SIRF_DELAY_LONG     4096
`define SIRF_DELAY_SHORT    256
`define SIRF_FETCH_CYC      2
`define SIRF_SYNC_STAGES    2

// Bus
`define SIRF_HTRANS_NONSEQ  2'h2
`define SIRF_HRESP_OKAY     1'h0

`endif

// ### sirf_pkg.sv
package sirf_pkg;

   typedef enum logic [1:0] {
      SIRF_RUN,
      SIRF_ACTIVE,
      SIRF_DELAY,
      SIRF_FETCH
   } sirf_seq_t;

   typedef struct packed {
      logic       short_delay;
      logic [1:0] level;
      logic       lvd_en;
   } sirf_opt_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] idx;
   } sirf_ap_t;

   typedef struct packed {
      logic warn_ie;
      logic lvd_flag;
      logic wdg_flag;
   } sirf_csr_t;

endpackage

// ### sirf_top_dummy_never.sv
`timescale 1ns/1ns

// ### sirf_top_sva.sv
`timescale 1ns/1ns
module sirf_top_sva
   import sirf_pkg::*;
#(
   parameter int WDG_PULSE_NS = 1000
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Reset sources and pin
   input wire logic       lvd_below_async,
   input wire logic       lvd_enable,
   input wire logic       wdg_underflow,
   input wire logic       illegal_opcode,
   input wire logic       rst_pin_out,
   input wire logic       rst_pin_oe,
   input wire logic       chip_reset,
   input wire logic       vector_fetch,
   // Interrupt side
   input wire logic       cpu_irq_masked,
   input wire logic [1:0] cpu_level,
   input wire logic       irq_ack,
   input wire logic       warn_irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Two sync stages plus the pin enable flop
   property p_lvd_pin;
      lvd_below_async && lvd_enable |-> ##[1:4] rst_pin_oe;
   endproperty
   a_lvd_pin: assert property (p_lvd_pin) else $error("pin not pulled on low supply");
   property p_pin_low;
      rst_pin_oe |-> !rst_pin_out;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin driven high");
   property p_wdg_pulse;
      wdg_underflow |=> rst_pin_oe [*5];
   endproperty
   a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog pulse short");
   property p_opcode;
      illegal_opcode |=> chip_reset && rst_pin_oe;
   endproperty
   a_opcode: assert property (p_opcode) else $error("no reset on opcode");
   property p_fetch_two;
      $rose(vector_fetch) |=> vector_fetch ##1 !vector_fetch;
   endproperty
   a_fetch_two: assert property (p_fetch_two) else $error("fetch not two cycles");
   property p_fetch_after;
      $fell(chip_reset) |-> vector_fetch && !rst_pin_oe;
   endproperty
   a_fetch_after: assert property (p_fetch_after) else $error("no fetch after delay");
   property p_masked;
      cpu_irq_masked |=> !warn_irq;
   endproperty
   a_masked: assert property (p_masked) else $error("request while masked");
   property p_level;
      cpu_level == 2'h3 |=> !warn_irq;
   endproperty
   a_level: assert property (p_level) else $error("request at top level");
   property p_ack;
      irq_ack |=> !warn_irq;
   endproperty
   a_ack: assert property (p_ack) else $error("request kept after entry");
   c_irq: cover property ($rose(warn_irq));
   c_wdg: cover property (wdg_underflow ##1 rst_pin_oe);
   c_fetch: cover property ($rose(vector_fetch));
endmodule
bind sirf_top sirf_top_sva #(.WDG_PULSE_NS(WDG_PULSE_NS)) i_sva (
   .ref_clk(ref_clk), .rst(rst), .lvd_below_async(lvd_below_async),
   .lvd_enable(lvd_enable), .wdg_underflow(wdg_underflow), .illegal_opcode(illegal_opcode),
   .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .chip_reset(chip_reset),
   .vector_fetch(vector_fetch), .cpu_irq_masked(cpu_irq_masked), .cpu_level(cpu_level),
   .irq_ack(irq_ack), .warn_irq(warn_irq));

// ### sirf_cpu_model.sv
`timescale 1ns/1ns
module sirf_cpu_model (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Interrupt side
   input wire logic       warn_irq,
   input wire logic       cpu_irq_masked,
   input wire logic       accept,
   input wire logic [3:0] lat,
   output logic           irq_ack,
   output int             ack_count
);
   logic [3:0] wait_cnt;
   // Entry takes lat+1 cycles; accept low models a core busy elsewhere
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_ack <= 1'b0;
         wait_cnt <= 4'h0;
         ack_count <= 0;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (warn_irq && accept && !cpu_irq_masked) begin
         if (wait_cnt == lat) begin
            irq_ack <= 1'b1;
            ack_count <= ack_count + 1;
         end else
            wait_cnt <= wait_cnt + 4'h1;
      end else
         wait_cnt <= 4'h0;
   end
endmodule

// ### testbench.sv
`timescale 1ns/1ns
`include "sirf_cfg.svh"
module testbench
   import sirf_pkg::*;
;
   logic        ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0, lvd_level, level = 2'h0;
   logic        hreadyout, lvd_b = 1'b0, avd_b = 1'b0, lvd_enable, wdg = 1'b0;
   logic        illegal = 1'b0, ext_low = 1'b0, rst_pin_out, rst_pin_oe, chip_reset;
   logic        vector_fetch, masked = 1'b0, irq_ack, cpu_wait = 1'b0, cpu_halt = 1'b0;
   logic        warn_irq, wake_wait, accept = 1'b1;
   logic [3:0]  lat = 4'h0;
   logic        opt_en = 1'b1, opt_short = 1'b1;
   logic [1:0]  opt_lvl = 2'h2;
   wire         rst_pin_in = !(rst_pin_oe && !rst_pin_out) && !ext_low;
   int          err_total = 0, samples_checked = 0, ack_count, n;
   always #5 ref_clk = ~ref_clk;
   sirf_top #(.WDG_PULSE_NS(50)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lvd_below_async(lvd_b),
      .avd_below_async(avd_b), .lvd_enable(lvd_enable), .lvd_level(lvd_level),
      .opt_lvd_en(opt_en), .opt_lvd_level(opt_lvl), .opt_short_delay(opt_short),
      .wdg_underflow(wdg), .illegal_opcode(illegal), .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .chip_reset(chip_reset),
      .vector_fetch(vector_fetch), .cpu_irq_masked(masked), .cpu_level(level),
      .irq_ack(irq_ack), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
      .warn_irq(warn_irq), .wake_wait(wake_wait));
   sirf_cpu_model i_cpu (
      .ref_clk(ref_clk), .rst(rst), .warn_irq(warn_irq), .cpu_irq_masked(masked),
      .accept(accept), .lat(lat), .irq_ack(irq_ack), .ack_count(ack_count));
   task report_and_stop;
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int k;
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      htrans <= `SIRF_HTRANS_NONSEQ;
      hwrite <= wr;
      for (int ph = 0; ph < 2; ph++) begin
         k = 0;
         do begin
            @(posedge ref_clk);
            k++;
         end while (hreadyout !== 1'b1 && k < 50);
         if (k >= 50) begin
            err_total++;
            report_and_stop;
         end
         // Data phase opens only once; the next call may raise the strobes at this edge
         if (ph == 0) begin
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= wd;
         end
      end
      rd = hrdata;
   endtask
   task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask
   task wait_run;
      int k;
      k = 0;
      repeat (3) @(posedge ref_clk);
      while ((chip_reset !== 1'b0 || vector_fetch !== 1'b0) && k < 2000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 2000) begin
         err_total++;
         report_and_stop;
      end
   endtask
   task settle(input int c, input int acks);
      repeat (c) @(posedge ref_clk);
      chk(ack_count, acks);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      n = 0;
      while (vector_fetch !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      chk(n >= `SIRF_DELAY_SHORT && n <= `SIRF_DELAY_SHORT + 4, 1);
      if (n >= 400)
         report_and_stop;
      rd_chk(`SIRF_CSR_IDX, {24'h000000, `SIRF_CSR_RST});
      rd_chk(`SIRF_OPT_IDX, 32'h0000000D);
      rd_chk(`SIRF_PRIO_IDX, {30'h00000000, `SIRF_PRIO_RST});
      chk(lvd_level, 2'h2);
      chk({hresp, lvd_enable}, 2'h1);
      avd_b <= 1'b1;
      repeat (8) @(posedge ref_clk);
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000000);
      rd_chk(`SIRF_CSR_IDX, 32'h00000020);
      settle(4, 0);
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000040);
      settle(12, 1);
      lat <= 4'h3;
      avd_b <= 1'b0;
      settle(16, 2);
      masked <= 1'b1;
      avd_b <= 1'b1;
      settle(12, 2);
      masked <= 1'b0;
      settle(12, 3);
      level <= 2'h3;
      avd_b <= 1'b0;
      settle(12, 3);
      level <= 2'h0;
      settle(12, 4);
      bus(1'b1, `SIRF_PRIO_IDX, 32'h00000003);
      rd_chk(`SIRF_PRIO_IDX, 32'h00000003);
      accept <= 1'b0;
      cpu_wait <= 1'b1;
      avd_b <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(wake_wait, 1'b1);
      accept <= 1'b1;
      cpu_wait <= 1'b0;
      settle(12, 5);
      chk(wake_wait, 1'b0);
      cpu_halt <= 1'b1;
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000000);
      avd_b <= 1'b0;
      settle(10, 5);
      rd_chk(`SIRF_CSR_IDX, 32'h00000060);
      cpu_halt <= 1'b0;
      // Reserved bits 3:1 stay clear; bit 7 and the read-only flag are set
      bus(1'b1, `SIRF_CSR_IDX, 32'h000000F1);
      rd_chk(`SIRF_CSR_IDX, 32'h00000040);
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000000);
      wdg <= 1'b1;
      @(posedge ref_clk);
      wdg <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(rst_pin_in, 1'b0);
      wait_run;
      rd_chk(`SIRF_CSR_IDX, 32'h00000001);
      // Supply warning clears while the chip is still in reset
      lvd_b <= 1'b1;
      avd_b <= 1'b1;
      repeat (20) @(posedge ref_clk);
      chk({rst_pin_in, chip_reset}, 2'h1);
      lvd_b <= 1'b0;
      avd_b <= 1'b0;
      wait_run;
      rd_chk(`SIRF_CSR_IDX, 32'h00000010);
      n = ack_count;
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000050);
      settle(12, n);
      for (int s = 0; s < 2; s++) begin
         if (s == 0)
            wdg <= 1'b1;
         else
            ext_low <= 1'b1;
         repeat (4) @(posedge ref_clk);
         wdg <= 1'b0;
         ext_low <= 1'b0;
         wait_run;
         rd_chk(`SIRF_CSR_IDX, 32'h00000011);
      end
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000000);
      rd_chk(`SIRF_CSR_IDX, 32'h00000000);
      ext_low <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_low <= 1'b0;
      wait_run;
      rd_chk(`SIRF_CSR_IDX, 32'h00000000);
      illegal <= 1'b1;
      @(posedge ref_clk);
      illegal <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(chip_reset, 1'b1);
      wait_run;
      rd_chk(`SIRF_CSR_IDX, 32'h00000000);
      rd_chk(8'h30, 32'h00000000);
      // Second power-on reset with the detector optioned out and the long delay
      rst <= 1'b1;
      opt_en <= 1'b0;
      opt_lvl <= 2'h1;
      opt_short <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      n = 0;
      while (vector_fetch !== 1'b1 && n < 4200) begin
         @(posedge ref_clk);
         n++;
      end
      chk(n >= `SIRF_DELAY_LONG && n <= `SIRF_DELAY_LONG + 4, 1);
      if (n >= 4200)
         report_and_stop;
      rd_chk(`SIRF_OPT_IDX, 32'h00000002);
      chk({lvd_enable, lvd_level}, 3'h1);
      lvd_b <= 1'b1;
      avd_b <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(chip_reset, 1'b0);
      bus(1'b0, `SIRF_CSR_IDX, 32'h00000000);
      // The low-supply flag has no defined value with the detector optioned out
      chk(rd & 32'hFFFFFFEF, 32'h00000000);
      bus(1'b1, `SIRF_CSR_IDX, 32'h00000040);
      settle(12, 0);
      report_and_stop;
   end
endmodule
